// ---- msc_defs.svh ----
// constants for module standby and clock output control
`ifndef MSC_DEFS_SVH
`define MSC_DEFS_SVH
`define MSC_OFF_MSTOP 12'h000
`define MSC_OFF_PWR 12'h004
`define MSC_OFF_DIR 12'h008
`define MSC_OFF_DAT 12'h00c
`define MSC_BANK_TAG 6'h01
`define MSC_BIT_CKDIS 7
`define MSC_BIT_TMR 5
`define MSC_BIT_CHA 4
`define MSC_BIT_CHB 3
`define MSC_BIT_ADC 0
`define MSC_MSTOP_MASK 8'hb9
`define MSC_MSTOP_RST 8'h00
`define MSC_BIT_SLEEP 0
`define MSC_BIT_SWSTBY 1
`define MSC_FLAG_IDX 2'h3
`define MSC_STOP_RDATA 32'h0000_00ff
`define MSC_SYNC_RST 1'b0
`endif

// ---- msc_pkg.sv ----
// types shared by the standby and clock output control block
package msc_pkg;
    typedef enum logic [4:0] {
        ST_RESET = 5'h01,
        ST_NORMAL = 5'h02,
        ST_SLEEP = 5'h04,
        ST_SWSTBY = 5'h08,
        ST_HWSTBY = 5'h10
    } msc_state_t;

    typedef struct packed {
        logic [3:0] dout;
        logic [3:0] oe;
    } msc_pins_t;
endpackage : msc_pkg

// ---- msc_regbank.sv ----
// register bank of one gated supporting module
`timescale 1ns/1ns
`default_nettype none
`include "msc_defs.svh"
module msc_regbank #(
    parameter int NREG = 4,
    parameter int W = 8
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic stop,
    input wire logic clr,
    input wire logic wr_en,
    input wire logic [1:0] idx,
    input wire logic [W-1:0] wdata,
    input wire logic event_in,
    output logic [W-1:0] rdata,
    output logic irq
);
    logic [W-1:0] reg_r [NREG];
    logic [W-1:0] flag_nxt;

    // stopped bank reads as all ones
    assign rdata = stop ? W'(`MSC_STOP_RDATA) : reg_r[idx];
    assign irq = reg_r[`MSC_FLAG_IDX][0];
    // write one clears, a same-cycle event still wins
    assign flag_nxt = (wr_en && idx == `MSC_FLAG_IDX) ?
        (reg_r[`MSC_FLAG_IDX] & ~wdata) : reg_r[`MSC_FLAG_IDX];

    always_ff @(posedge mclk)
    begin
        for (int i = 0; i < NREG; i++)
        begin
            if (!rst_n || stop || clr)
                reg_r[i] <= '0;
            else if (i == int'(`MSC_FLAG_IDX))
                reg_r[i] <= flag_nxt | {{(W-1){1'b0}}, event_in};
            else if (wr_en && idx == 2'(i))
                reg_r[i] <= wdata;
        end
    end

    chk_stop_clears: assert property (@(posedge mclk) disable iff (!rst_n)
        stop |=> (reg_r[0] == '0 && reg_r[1] == '0 && reg_r[2] == '0))
        else $error("stopped bank kept a register value");
    chk_irq_dropped: assert property (@(posedge mclk) disable iff (!rst_n)
        (stop && event_in) |=> !irq)
        else $error("interrupt held while module stopped");
    chk_stop_reads: assert property (@(posedge mclk) disable iff (!rst_n)
        stop |-> rdata == W'(`MSC_STOP_RDATA))
        else $error("stopped bank did not read 0xff");
endmodule : msc_regbank
`default_nettype wire

// ---- msc_clkout.sv ----
// system clock output pin control
`timescale 1ns/1ns
`default_nettype none
module msc_clkout
    import msc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic disable_out,
    input wire msc_state_t state,
    output logic pin_out,
    output logic pin_oe
);
    logic run;
    logic run_r;
    // the pin carries the system clock as a half-rate toggle so it leaves a flop
    assign run = !disable_out && (state == ST_NORMAL || state == ST_SLEEP);

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
            run_r <= 1'b0;
        end
        else
        begin
            run_r <= run;
            pin_oe <= !disable_out && state != ST_HWSTBY;
            if (run)
                pin_out <= !pin_out;
            else
                pin_out <= 1'b1;
        end
    end

    chk_dis_floats: assert property (@(posedge mclk) disable iff (!rst_n)
        disable_out |=> !pin_oe)
        else $error("clock pin driven while disabled");
    chk_clk_toggles: assert property (@(posedge mclk) disable iff (!rst_n)
        (run && run_r) |=> pin_out != $past(pin_out) && pin_oe)
        else $error("clock output not running");
    chk_swstby_high: assert property (@(posedge mclk) disable iff (!rst_n)
        (!disable_out && state == ST_SWSTBY) |=> pin_out && pin_oe)
        else $error("clock pin not high in soft standby");
    chk_hw_float: assert property (@(posedge mclk) disable iff (!rst_n)
        state == ST_HWSTBY |=> !pin_oe)
        else $error("clock pin driven in hardware standby");
endmodule : msc_clkout
`default_nettype wire

// ---- msc_ctrl.sv ----
// module standby, power state and clock output controller with apb slave
`timescale 1ns/1ns
`default_nettype none
`include "msc_defs.svh"
module msc_ctrl
    import msc_pkg::*;
#(
    parameter int AW = 12,
    parameter int NMOD = 4,
    parameter int BW = 8
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_reset_pin_n,
    input wire logic hw_standby_pin_n,
    input wire logic wake_pin,
    input wire logic [NMOD-1:0] mod_event,
    input wire msc_pins_t mod_fn,
    output logic [NMOD-1:0] mod_irq,
    output logic [NMOD-1:0] mod_stop,
    output msc_pins_t port_pins,
    output logic clk_out_pin,
    output logic clk_out_oe,
    output msc_state_t pwr_state
);
    logic rst_s1_r;
    logic rst_s2_r;
    logic hw_standby_pin_n_s1_r;
    logic hw_standby_pin_n_s2_r;
    logic wake_s1_r;
    logic wake_s2_r;
    logic [7:0] mstop_r;
    logic [3:0] dir_r;
    logic [3:0] dat_r;
    msc_state_t st_r;
    msc_state_t st_nxt;
    logic [BW-1:0] bank_rd [NMOD];

    wire logic setup = psel && !penable;
    wire logic acc = psel && penable && pready;
    wire logic wr = acc && pwrite;
    wire logic hit_mst = paddr == `MSC_OFF_MSTOP;
    wire logic hit_pwr = paddr == `MSC_OFF_PWR;
    wire logic hit_dir = paddr == `MSC_OFF_DIR;
    wire logic hit_dat = paddr == `MSC_OFF_DAT;
    wire logic hit_bank = paddr[AW-1:6] == (AW-6)'(`MSC_BANK_TAG);
    wire logic hit = hit_mst || hit_pwr || hit_dir || hit_dat || hit_bank;
    wire logic [1:0] bsel = paddr[5:4];
    wire logic [1:0] bidx = paddr[3:2];
    // registers of every module are cleared while the chip is held
    wire logic chip_clr = st_r == ST_RESET || st_r == ST_HWSTBY;
    wire logic [NMOD-1:0] stop_v = {mstop_r[`MSC_BIT_ADC], mstop_r[`MSC_BIT_CHB],
        mstop_r[`MSC_BIT_CHA], mstop_r[`MSC_BIT_TMR]};
    wire logic [31:0] rd_mux =
        hit_mst ? {24'h0, mstop_r} :
        hit_pwr ? {27'h0, st_r} :
        hit_dir ? {28'h0, dir_r} :
        hit_dat ? {28'h0, dat_r} :
        hit_bank ? {{(32-BW){1'b0}}, bank_rd[bsel]} : 32'h0;
    wire logic req_sleep = wr && hit_pwr && pwdata[`MSC_BIT_SLEEP];
    wire logic req_swstby = wr && hit_pwr && pwdata[`MSC_BIT_SWSTBY];

    assign mod_stop = stop_v;
    assign pwr_state = st_r;

    // pins pass two flops before any logic looks at them
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            rst_s1_r <= `MSC_SYNC_RST;
            rst_s2_r <= `MSC_SYNC_RST;
            hw_standby_pin_n_s1_r <= 1'b1;
            hw_standby_pin_n_s2_r <= 1'b1;
            wake_s1_r <= 1'b0;
            wake_s2_r <= 1'b0;
        end
        else
        begin
            rst_s1_r <= ext_reset_pin_n;
            rst_s2_r <= rst_s1_r;
            hw_standby_pin_n_s1_r <= hw_standby_pin_n;
            hw_standby_pin_n_s2_r <= hw_standby_pin_n_s1_r;
            wake_s1_r <= wake_pin;
            wake_s2_r <= wake_s1_r;
        end
    end

    // standby pin overrides everything; leaving it still waits for reset release
    always_comb
    begin
        st_nxt = st_r;
        if (!hw_standby_pin_n_s2_r)
            st_nxt = ST_HWSTBY;
        else if (!rst_s2_r)
            st_nxt = ST_RESET;
        else
        begin
            unique case (st_r)
                ST_RESET: st_nxt = ST_NORMAL;
                ST_NORMAL:
                begin
                    if (req_swstby)
                        st_nxt = ST_SWSTBY;
                    else if (req_sleep)
                        st_nxt = ST_SLEEP;
                end
                ST_SLEEP: st_nxt = wake_s2_r ? ST_NORMAL : ST_SLEEP;
                ST_SWSTBY: st_nxt = wake_s2_r ? ST_NORMAL : ST_SWSTBY;
                ST_HWSTBY: st_nxt = ST_RESET;
                default: st_nxt = ST_RESET;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            st_r <= ST_RESET;
        else
            st_r <= st_nxt;
    end

    // write lands on the access edge, so the module halts from the next clock cycle
    always_ff @(posedge mclk)
    begin
        if (!rst_n || chip_clr)
        begin
            mstop_r <= `MSC_MSTOP_RST;
            dir_r <= 4'h0;
            dat_r <= 4'h0;
        end
        else if (wr)
        begin
            if (hit_mst)
                mstop_r <= pwdata[7:0] & `MSC_MSTOP_MASK;
            if (hit_dir)
                dir_r <= pwdata[3:0];
            if (hit_dat)
                dat_r <= pwdata[3:0];
        end
    end

    // read data is formed during setup so every output leaves a flop
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup && !hit;
            prdata <= (setup && !pwrite) ? rd_mux : 32'h0;
        end
    end

    // gating is independent of the power state, only stop and chip clear matter
    for (genvar m = 0; m < NMOD; m++)
    begin : g_bank
        msc_regbank #(
            .NREG(4),
            .W(BW)
        ) u_bank (
            .mclk(mclk),
            .rst_n(rst_n),
            .stop(stop_v[m]),
            .clr(chip_clr),
            .wr_en(wr && hit_bank && bsel == 2'(m)),
            .idx(bidx),
            .wdata(pwdata[BW-1:0]),
            .event_in(mod_event[m]),
            .rdata(bank_rd[m]),
            .irq(mod_irq[m])
        );
    end

    // a stopped module hands its pins to port direction and data
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            port_pins <= '0;
        else if (st_r == ST_HWSTBY)
            port_pins <= '0;
        else
        begin
            for (int i = 0; i < NMOD; i++)
            begin
                port_pins.oe[i] <= stop_v[i] ? dir_r[i] : mod_fn.oe[i];
                port_pins.dout[i] <= stop_v[i] ? dat_r[i] : mod_fn.dout[i];
            end
        end
    end

    msc_clkout u_clkout (
        .mclk(mclk),
        .rst_n(rst_n),
        .disable_out(mstop_r[`MSC_BIT_CKDIS]),
        .state(st_r),
        .pin_out(clk_out_pin),
        .pin_oe(clk_out_oe)
    );

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    chk_stop_timing: assert property (
        (wr && hit_mst && !chip_clr && pwdata[`MSC_BIT_TMR]) |=> mod_stop[0])
        else $error("stop bit did not take effect after write");
    chk_stop_map: assert property (
        (wr && hit_mst && !chip_clr)
        |=> mod_stop == {$past(pwdata[0]), $past(pwdata[3]), $past(pwdata[4]), $past(pwdata[5])})
        else $error("stop bits mapped to wrong modules");
    chk_stop_rd_ff: assert property (
        (setup && !pwrite && hit_bank && stop_v[bsel]) |=> prdata == `MSC_STOP_RDATA)
        else $error("stopped module register did not read 0xff");
    chk_stop_wr_ign: assert property (
        (wr && hit_bank && stop_v[bsel] && bidx != 2'h3) ##2 (stop_v[bsel] && setup && !pwrite && hit_bank)
        |=> prdata == `MSC_STOP_RDATA)
        else $error("write reached stopped module");
    chk_hw_enter: assert property (
        !hw_standby_pin_n_s2_r |=> st_r == ST_HWSTBY)
        else $error("standby pin did not force hardware standby");
    chk_hw_ports: assert property (
        st_r == ST_HWSTBY |=> port_pins.oe == 4'h0 && mod_stop == '0)
        else $error("ports driven in hardware standby");
    chk_hw_exit: assert property (
        (st_r == ST_HWSTBY && hw_standby_pin_n_s2_r && !rst_s2_r) |=> st_r == ST_RESET [*2])
        else $error("left standby before reset release");
    chk_pin_release: assert property (
        (st_r == ST_NORMAL && stop_v[1] && $stable(dir_r)) |=> port_pins.oe[1] == $past(dir_r[1]))
        else $error("stopped module pin not under port control");

    // bus answer comes one cycle after setup and is never stretched
    chk_ready_once: assert property (
        pready |=> !pready)
        else $error("ready held longer than one cycle");

    chk_ready_setup: assert property (
        setup |=> pready)
        else $error("ready missing after setup");

    chk_err_ready: assert property (
        pslverr |-> pready)
        else $error("error flag without ready");

    chk_rdata_idle: assert property (
        !pready |-> prdata == 32'h0)
        else $error("read data outside access cycle");

    chk_wr_rdata: assert property (
        (setup && pwrite) |=> prdata == 32'h0)
        else $error("read data driven during write");

    chk_unmapped_err: assert property (
        (setup && !hit) |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not flagged");

    // power state sequencing
    chk_state_onehot: assert property (
        $onehot(st_r))
        else $error("power state not one-hot");

    chk_reset_hold: assert property (
        (hw_standby_pin_n_s2_r && !rst_s2_r) |=> st_r == ST_RESET)
        else $error("left reset while reset pin low");

    chk_reset_exit: assert property (
        (st_r == ST_RESET && hw_standby_pin_n_s2_r && rst_s2_r) |=> st_r == ST_NORMAL)
        else $error("no normal state after reset release");

    chk_hw_clears: assert property (
        st_r == ST_HWSTBY |=> mstop_r == `MSC_MSTOP_RST && dir_r == 4'h0)
        else $error("registers kept in hardware standby");

    chk_sleep_enter: assert property (
        (st_r == ST_NORMAL && hw_standby_pin_n_s2_r && rst_s2_r && req_sleep && !req_swstby) |=> st_r == ST_SLEEP)
        else $error("sleep request not taken");

    chk_swstby_enter: assert property (
        (st_r == ST_NORMAL && hw_standby_pin_n_s2_r && rst_s2_r && req_swstby) |=> st_r == ST_SWSTBY)
        else $error("soft standby request not taken");

    chk_wake_exit: assert property (
        ((st_r == ST_SLEEP || st_r == ST_SWSTBY) && hw_standby_pin_n_s2_r && rst_s2_r && wake_s2_r) |=> st_r == ST_NORMAL)
        else $error("wake did not return to normal");

    chk_stop_mask: assert property (
        (mstop_r & ~`MSC_MSTOP_MASK) == 8'h00)
        else $error("unused stop register bit set");

    chk_pin_fn: assert property (
        (st_r != ST_HWSTBY && !stop_v[0])
        |=> port_pins.oe[0] == $past(mod_fn.oe[0]) && port_pins.dout[0] == $past(mod_fn.dout[0]))
        else $error("running module lost its pin");
endmodule : msc_ctrl
`default_nettype wire

// ---- msc_pin_host.sv ----
// behavioural host that drives the reset and standby pins
`timescale 1ns/1ns
`default_nettype none
module msc_pin_host #(
    parameter int SETTLE = 8
) (
    input wire logic mclk,
    output logic ext_reset_pin_n,
    output logic hw_standby_pin_n
);
    initial
    begin
        ext_reset_pin_n = 1'b0;
        hw_standby_pin_n = 1'b1;
    end
    // gap stretches the spacing between the two pin moves
    task automatic enter_hw_standby_pin_n(input int gap);
        @(posedge mclk);
        ext_reset_pin_n <= 1'b0;
        repeat (gap + 1) @(posedge mclk);
        hw_standby_pin_n <= 1'b0;
    endtask : enter_hw_standby_pin_n
    // reset stays low until the clock has had time to settle
    task automatic leave_hw_standby_pin_n(input int gap);
        @(posedge mclk);
        hw_standby_pin_n <= 1'b1;
        repeat (gap + SETTLE) @(posedge mclk);
        ext_reset_pin_n <= 1'b1;
    endtask : leave_hw_standby_pin_n
endmodule : msc_pin_host
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench for the standby and clock output controller
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import msc_pkg::*;
    typedef struct packed {logic wr; logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} msc_row_t;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic wake_pin = 1'b0;
    logic [3:0] mod_event = 4'h0;
    msc_pins_t mod_fn = 8'h53;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, ck;
    logic ext_reset_pin_n, hw_standby_pin_n, clk_out_pin, clk_out_oe;
    logic [3:0] mod_irq, mod_stop;
    msc_pins_t port_pins;
    msc_state_t pwr_state;
    int error_cnt = 0;
    int comparisons = 0;
    int bits[4] = '{5, 4, 3, 0};
    msc_row_t rows[16] = '{
        '{1'b0, 12'h000, 32'h0, 32'h0, 1'b0}, '{1'b1, 12'h000, 32'hff, 32'h0, 1'b0},
        '{1'b0, 12'h000, 32'h0, 32'hb9, 1'b0}, '{1'b1, 12'h000, 32'h0, 32'h0, 1'b0},
        '{1'b0, 12'h004, 32'h0, 32'h2, 1'b0}, '{1'b1, 12'h008, 32'hf, 32'h0, 1'b0},
        '{1'b0, 12'h008, 32'h0, 32'hf, 1'b0}, '{1'b1, 12'h00c, 32'ha, 32'h0, 1'b0},
        '{1'b0, 12'h00c, 32'h0, 32'ha, 1'b0}, '{1'b1, 12'h044, 32'h5a, 32'h0, 1'b0},
        '{1'b0, 12'h044, 32'h0, 32'h5a, 1'b0}, '{1'b1, 12'h000, 32'h1, 32'h0, 1'b0},
        '{1'b0, 12'h070, 32'h0, 32'hff, 1'b0}, '{1'b1, 12'h000, 32'h0, 32'h0, 1'b0},
        '{1'b0, 12'h010, 32'h0, 32'h0, 1'b1}, '{1'b1, 12'h3f0, 32'h0, 32'h0, 1'b1}};
    msc_ctrl dut (.mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_reset_pin_n(ext_reset_pin_n), .hw_standby_pin_n(hw_standby_pin_n),
        .wake_pin(wake_pin), .mod_event(mod_event), .mod_fn(mod_fn), .mod_irq(mod_irq),
        .mod_stop(mod_stop), .port_pins(port_pins), .clk_out_pin(clk_out_pin),
        .clk_out_oe(clk_out_oe), .pwr_state(pwr_state));
    msc_pin_host host (.mclk(mclk), .ext_reset_pin_n(ext_reset_pin_n),
        .hw_standby_pin_n(hw_standby_pin_n));
    always #2 mclk = ~mclk;
    task automatic tally_and_finish();
        if (error_cnt == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    task automatic chk_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk_val
    task automatic chk_state(input msc_state_t exp);
        comparisons++;
        if (pwr_state !== exp)
        begin
            error_cnt++;
            $display("unexpected pwr_state expected %h seen %h", exp, pwr_state);
        end
    endtask : chk_state
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
        begin
            error_cnt++;
            tally_and_finish();
        end
    endtask : apb
    task automatic wait_state(input msc_state_t s);
        int n;
        n = 0;
        while (pwr_state !== s && n < 200)
        begin
            @(posedge mclk);
            n++;
        end
        chk_state(s);
        if (n >= 200)
            tally_and_finish();
    endtask : wait_state
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : settle
    task automatic pulse_event();
        @(posedge mclk);
        mod_event <= 4'h1;
        @(posedge mclk);
        mod_event <= 4'h0;
        settle(2);
    endtask : pulse_event
    task automatic wake();
        @(posedge mclk);
        wake_pin <= 1'b1;
        wait_state(ST_NORMAL);
        wake_pin <= 1'b0;
        settle(4);
    endtask : wake
    initial
    begin
        #200000;
        error_cnt++;
        tally_and_finish();
    end
    initial
    begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        host.leave_hw_standby_pin_n(0);
        wait_state(ST_NORMAL);
        foreach (rows[i])
        begin
            apb(rows[i].wr, rows[i].a, rows[i].d);
            chk_val("pslverr", {31'h0, rows[i].e}, {31'h0, err});
            if (!rows[i].wr)
                chk_val("prdata", rows[i].q, rd);
        end
        foreach (bits[m])
        begin
            apb(1'b1, 12'h000, 32'h1 << bits[m]);
            settle(2);
            chk_val("mod_stop", 32'h1 << m, {28'h0, mod_stop});
        end
        apb(1'b1, 12'h000, 32'h0);
        pulse_event();
        chk_val("mod_irq", 32'h1, {28'h0, mod_irq});
        chk_val("pin0", 32'h3, {30'h0, port_pins.dout[0], port_pins.oe[0]});
        chk_val("port_pins", 32'h53, {24'h0, port_pins});
        @(posedge mclk);
        mod_fn <= 8'ha6;
        settle(2);
        chk_val("port_pins", 32'ha6, {24'h0, port_pins});
        apb(1'b1, 12'h04c, 32'h1);
        settle(1);
        chk_val("mod_irq", 32'h0, {28'h0, mod_irq});
        pulse_event();
        apb(1'b1, 12'h044, 32'h5a);
        apb(1'b0, 12'h044, 32'h0);
        chk_val("bank0", 32'h5a, rd);
        apb(1'b1, 12'h000, 32'h20);
        apb(1'b0, 12'h040, 32'h0);
        chk_val("bank0", 32'hff, rd);
        settle(1);
        chk_val("mod_irq", 32'h0, {28'h0, mod_irq});
        chk_val("pin0", 32'h1, {30'h0, port_pins.dout[0], port_pins.oe[0]});
        apb(1'b1, 12'h044, 32'h33);
        apb(1'b0, 12'h044, 32'h0);
        chk_val("bank0", 32'hff, rd);
        pulse_event();
        chk_val("mod_irq", 32'h0, {28'h0, mod_irq});
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b0, 12'h044, 32'h0);
        chk_val("bank0", 32'h0, rd);
        apb(1'b1, 12'h040, 32'h11);
        apb(1'b0, 12'h040, 32'h0);
        chk_val("bank0", 32'h11, rd);
        settle(1);
        ck = clk_out_pin;
        settle(1);
        chk_val("clk_out", {30'h0, ~ck, 1'b1}, {30'h0, clk_out_pin, clk_out_oe});
        apb(1'b1, 12'h000, 32'h80);
        apb(1'b1, 12'h004, 32'h2);
        wait_state(ST_SWSTBY);
        settle(2);
        chk_val("clk_out_oe", 32'h0, {31'h0, clk_out_oe});
        wake();
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h004, 32'h1);
        wait_state(ST_SLEEP);
        settle(2);
        ck = clk_out_pin;
        settle(1);
        chk_val("clk_out", {30'h0, ~ck, 1'b1}, {30'h0, clk_out_pin, clk_out_oe});
        wake();
        apb(1'b1, 12'h004, 32'h3);
        wait_state(ST_SWSTBY);
        settle(3);
        chk_val("clk_out", 32'h3, {30'h0, clk_out_pin, clk_out_oe});
        settle(1);
        chk_val("clk_out", 32'h3, {30'h0, clk_out_pin, clk_out_oe});
        wake();
        apb(1'b1, 12'h008, 32'hd);
        apb(1'b1, 12'h000, 32'h10);
        settle(2);
        chk_val("port_oe", 32'h4, {28'h0, port_pins.oe});
        apb(1'b1, 12'h000, 32'h21);
        host.enter_hw_standby_pin_n(2);
        wait_state(ST_HWSTBY);
        settle(2);
        chk_val("standby", 32'h0, {23'h0, clk_out_oe, port_pins.oe, mod_stop});
        host.leave_hw_standby_pin_n(2);
        wait_state(ST_NORMAL);
        apb(1'b0, 12'h000, 32'h0);
        chk_val("stop_reg", 32'h0, rd);
        apb(1'b1, 12'h000, 32'h21);
        @(posedge mclk);
        rst_n <= 1'b0;
        settle(2);
        chk_val("reset", 32'h1, {12'h0, pready, pslverr, clk_out_oe, mod_irq, mod_stop, port_pins.oe, pwr_state});
        @(posedge mclk);
        rst_n <= 1'b1;
        wait_state(ST_NORMAL);
        apb(1'b0, 12'h000, 32'h0);
        chk_val("stop_reg", 32'h0, rd);
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
